/* shared/scs_pkg.sv */
// Shared constants, register map and carrier types for the shading calibration sequencer.
package scs_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_CFG = 8'h08;
    localparam logic [7:0] A_THRESH = 8'h0C;
    localparam logic [7:0] A_GCNT = 8'h10;
    localparam logic [7:0] A_ADJ = 8'h14;
    localparam logic [7:0] A_AVG = 8'h18;
    localparam logic [7:0] A_BREF = 8'h1C;
    localparam logic [7:0] A_REFS = 8'h20;
    localparam logic [7:0] A_OFFS = 8'h40;
    localparam logic [7:0] A_OFFS_END = 8'h5C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned STAT_BUSY = 7;
    localparam int unsigned CFG_TYPE_LSB = 0;
    localparam int unsigned CFG_3SET = 2;
    localparam int unsigned CFG_CHEN_LSB = 4;
    localparam int unsigned REFS_PH_LSB = 0;
    localparam int unsigned REFS_BV_LSB = 8;
    localparam int unsigned REFS_WV_LSB = 16;

    // ------------------------------------------------------------------
    // Commands, sensor types and sequencing constants
    // ------------------------------------------------------------------
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_P2P = 2'h1;
    localparam logic [1:0] CMD_OFS = 2'h2;
    localparam logic [1:0] CMD_GAIN = 2'h3;
    localparam logic [1:0] SNS_3CH = 2'h0;
    localparam logic [1:0] SNS_1CH_COL = 2'h1;
    localparam logic [4:0] SCANS_P2P = 5'h10;
    localparam logic [4:0] SCANS_OFS = 5'h2;
    localparam logic [1:0] NCOL = 2'h3;
    localparam logic [2:0] BANK_COMMON = 3'h3;
    localparam logic [1:0] PAIR_COMMON = 2'h3;
    localparam logic [7:0] PHOLD_FULL = 8'hFF;
    localparam logic [7:0] REF_FULL = 8'h00;
    localparam logic [7:0] GCNT_MAX = 8'hFF;
    localparam logic [2:0] LED_CH0 = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARM = 3'b001,
        ST_PREP = 3'b010,
        ST_SCAN = 3'b011,
        ST_GPRE = 3'b100,
        ST_GCNT = 3'b101
    } scs_state_t;

    // Pixel stream from the front end, one sample per valid cycle.
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [12:0] index;
        logic [9:0] video;
        logic [7:0] black;
    } scs_pix_t;

    // Shading memory request.
    typedef struct packed {
        logic re;
        logic we;
        logic [12:0] addr;
        logic [2:0] bank;
        logic [8:0] wdata;
    } scs_sram_t;

endpackage : scs_pkg

/* rtl/scs_sync.sv */
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [1:0][W-1:0] stage_r;
    logic [1:0][W-1:0] stage_nxt;

    always_comb begin
        stage_nxt = {stage_r[0], async_i};
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            stage_r <= '0;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign sync_o = stage_r[1];
endmodule : scs_sync
`default_nettype wire

/* rtl/scs_sat_add.sv */
// Unsigned value plus signed adjustment, saturated to the unsigned range.
`timescale 1ns/1ps
`default_nettype none
module scs_sat_add #(
    parameter int unsigned W = 8
) (
    // Operands
    input wire logic [W-1:0] val_i,
    input wire logic signed [W-1:0] adj_i,
    // Result
    output logic [W-1:0] sum_o
);
    logic signed [W+1:0] sum;

    always_comb begin
        sum = $signed({2'b00, val_i}) + {{2{adj_i[W-1]}}, adj_i};
        if (sum < 0) begin
            sum_o = '0;
        end else if (sum[W]) begin
            sum_o = '1;
        end else begin
            sum_o = sum[W-1:0];
        end
    end
endmodule : scs_sat_add
`default_nettype wire

/* rtl/scs_seq.sv */
// Black shading detection and gain-adjust measurement sequencer with APB registers.
//
// Contract
// - Three-channel detection ends after 17, 3 or 7 lines.
// - Results go to SRAM bank or channel pair.
// - Busy flag in status bit seven shows completion.
// - Single-channel colour follows order; 49/17/7/3 lines.
// - Monochrome always processes sensor input zero.
// - Monochrome offsets land in common even/odd pair.
// - Signed adjustment shifts black correction uniformly.
// - Nonzero averaging count repeats detection N+1 times.
// - Count pixels whose video exceeds threshold.
// - Gain modes force peak FFh, references 00h.
// - Gain modes force black correction, disable white.
// - Three-channel gain measurement ends after two lines.
// - Single-channel gain: LED line then detecting line.
// - Scan m captures pixels at 16n+m.
// - One-set pixel mode uses memory bank 011B.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scs_seq (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [scs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sensor timing and pixel stream
    input wire logic line_trigger_i,
    input wire scs_pkg::scs_pix_t pix_i,
    // Shading memory
    output scs_pkg::scs_sram_t sram_o,
    input wire logic [8:0] sram_rdata_i,
    // Black correction path
    input wire logic [7:0] corr_data_i,
    output logic [7:0] corr_o,
    // Analog front-end control
    output logic [1:0] proc_chan_o,
    output logic [2:0] led_o,
    output logic [7:0] peak_hold_o,
    output logic [7:0] black_ref_volt_o,
    output logic [7:0] white_ref_volt_o,
    output logic black_corr_force_o,
    output logic white_shd_dis_o,
    output logic busy_o
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        scs_state_t st;
        logic busy;
        logic [1:0] mode;
        logic [4:0] cnt_scan;
        logic [1:0] cnt_col;
        logic [7:0] cnt_pass;
        logic line_trigger_d;
        logic [1:0] sensor;
        logic three_set;
        logic [2:0] chen;
        logic [7:0] thresh;
        logic [7:0] gcnt;
        logic [7:0] adj;
        logic [7:0] avg;
        logic [7:0] bref;
        logic [7:0] ph;
        logic [7:0] bv;
        logic [7:0] wv;
        logic [7:0][7:0] offs;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        scs_sram_t sram;
        logic rd_wait;
        logic [7:0] cap;
        logic [1:0] chan;
        logic [2:0] led;
        logic [7:0] corr;
        logic gforce;
        logic [7:0] ph_out;
        logic [7:0] bv_out;
        logic [7:0] wv_out;
    } scs_seq_state_t;

    scs_seq_state_t s_r;
    scs_seq_state_t s_nxt;
    logic line_trigger_sync;
    logic [7:0] corr_sum;

    scs_sync #(
        .W(1)
    ) u_line_trigger_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i(line_trigger_i),
        .sync_o(line_trigger_sync)
    );

    scs_sat_add #(
        .W(8)
    ) u_adj (
        .val_i(corr_data_i),
        .adj_i(s_r.adj),
        .sum_o(corr_sum)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic line_trigger_rise;
    logic mono;
    logic multi_col;
    logic [1:0] onehot_idx;
    logic [1:0] chan;
    logic [1:0] colours;
    logic [4:0] scans;
    logic [1:0] pair;
    logic [2:0] bank;
    logic pix_ok;
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic gain_act;
    logic [9:0] avg_sum;

    always_comb begin
        s_nxt = s_r;
        line_trigger_rise = line_trigger_sync & ~s_r.line_trigger_d;
        s_nxt.line_trigger_d = line_trigger_sync;
        mono = s_r.sensor[1];
        // Only one enable bit is expected; the lowest set bit wins otherwise.
        onehot_idx = s_r.chen[0] ? 2'h0 : (s_r.chen[1] ? 2'h1 : 2'h2);
        multi_col = s_r.three_set & ~mono & (s_r.mode != CMD_GAIN)
            & ((s_r.sensor == SNS_1CH_COL) | (s_r.mode == CMD_OFS));
        colours = multi_col ? NCOL : 2'h1;
        scans = (s_r.mode == CMD_P2P) ? SCANS_P2P : SCANS_OFS;
        // Multi-colour passes walk the preset colour order line by line.
        chan = mono ? 2'h0 : (multi_col ? s_r.cnt_col : onehot_idx);
        pair = (s_r.three_set & ~mono) ? chan : PAIR_COMMON;
        bank = (s_r.three_set & ~mono) ? {1'b0, chan} : BANK_COMMON;
        pix_ok = pix_i.valid & (pix_i.chan == chan);
        s_nxt.chan = chan;

        // APB: registered read data, answer in the first access cycle.
        setup = psel_i & ~penable_i;
        wr = psel_i & penable_i & s_r.pready & pwrite_i & ~s_r.pslverr;
        hit = 1'b1;
        rd = '0;
        case (paddr_i)
            A_STATUS: rd[STAT_BUSY] = s_r.busy;
            A_CMD: rd = '0;
            A_CFG: begin
                rd[CFG_TYPE_LSB +: 2] = s_r.sensor;
                rd[CFG_3SET] = s_r.three_set;
                rd[CFG_CHEN_LSB +: 3] = s_r.chen;
            end
            A_THRESH: rd[7:0] = s_r.thresh;
            A_GCNT: rd[7:0] = s_r.gcnt;
            A_ADJ: rd[7:0] = s_r.adj;
            A_AVG: rd[7:0] = s_r.avg;
            A_BREF: rd[7:0] = s_r.bref;
            A_REFS: rd = {8'h00, s_r.wv, s_r.bv, s_r.ph};
            default: begin
                if (paddr_i >= A_OFFS && paddr_i <= A_OFFS_END && paddr_i[1:0] == 2'h0) begin
                    rd[7:0] = s_r.offs[paddr_i[4:2]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~hit;
        s_nxt.prdata = setup ? rd : '0;
        if (wr) begin
            case (paddr_i)
                A_CFG: begin
                    s_nxt.sensor = pwdata_i[CFG_TYPE_LSB +: 2];
                    s_nxt.three_set = pwdata_i[CFG_3SET];
                    s_nxt.chen = pwdata_i[CFG_CHEN_LSB +: 3];
                end
                A_THRESH: s_nxt.thresh = pwdata_i[7:0];
                A_ADJ: s_nxt.adj = pwdata_i[7:0];
                A_AVG: s_nxt.avg = pwdata_i[7:0];
                A_BREF: s_nxt.bref = pwdata_i[7:0];
                A_REFS: begin
                    s_nxt.ph = pwdata_i[REFS_PH_LSB +: 8];
                    s_nxt.bv = pwdata_i[REFS_BV_LSB +: 8];
                    s_nxt.wv = pwdata_i[REFS_WV_LSB +: 8];
                end
                default: begin
                end
            endcase
        end

        // Shading memory: write-back of an averaged sample, one cycle after read data.
        s_nxt.sram.re = 1'b0;
        s_nxt.sram.we = 1'b0;
        s_nxt.rd_wait = s_r.sram.re;
        avg_sum = {1'b0, sram_rdata_i} + {2'b00, s_r.cap};
        if (s_r.rd_wait) begin
            s_nxt.sram.we = 1'b1;
            s_nxt.sram.wdata = avg_sum[9:1];
        end

        // Line sequencer.
        case (s_r.st)
            ST_IDLE: begin
                // A command written while busy is dropped.
                if (wr && paddr_i == A_CMD && pwdata_i[1:0] != CMD_NONE) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.mode = pwdata_i[1:0];
                    s_nxt.st = ST_ARM;
                    s_nxt.cnt_scan = '0;
                    s_nxt.cnt_col = '0;
                    s_nxt.cnt_pass = '0;
                    if (pwdata_i[1:0] == CMD_GAIN) begin
                        s_nxt.gcnt = '0;
                    end
                end
            end
            ST_ARM: begin
                // The command is asynchronous to the line, so one line is lost here.
                if (line_trigger_rise) begin
                    s_nxt.st = (s_r.mode == CMD_GAIN) ? ST_GPRE : ST_PREP;
                end
            end
            ST_PREP: begin
                if (line_trigger_rise) begin
                    s_nxt.st = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (pix_ok && s_r.mode == CMD_P2P && pix_i.index[3:0] == s_r.cnt_scan[3:0]) begin
                    s_nxt.sram.addr = pix_i.index;
                    s_nxt.sram.bank = bank;
                    s_nxt.cap = pix_i.black;
                    if (s_r.cnt_pass == 8'h00) begin
                        s_nxt.sram.we = 1'b1;
                        s_nxt.sram.wdata = {1'b0, pix_i.black};
                    end else begin
                        s_nxt.sram.re = 1'b1;
                    end
                end
                if (pix_ok && s_r.mode == CMD_OFS
                        && pix_i.index == {2'b00, s_r.bref, 3'b000} + {8'h00, s_r.cnt_scan}) begin
                    s_nxt.offs[{pair, s_r.cnt_scan[0]}] = pix_i.black;
                end
                if (line_trigger_rise) begin
                    if (s_r.cnt_col + 2'h1 < colours) begin
                        s_nxt.cnt_col = s_r.cnt_col + 2'h1;
                    end else begin
                        s_nxt.cnt_col = '0;
                        if (s_r.cnt_scan + 5'h1 < scans) begin
                            s_nxt.cnt_scan = s_r.cnt_scan + 5'h1;
                        end else begin
                            s_nxt.cnt_scan = '0;
                            if (s_r.mode == CMD_P2P && s_r.cnt_pass != s_r.avg) begin
                                s_nxt.cnt_pass = s_r.cnt_pass + 8'h01;
                            end else begin
                                s_nxt.st = ST_IDLE;
                                s_nxt.busy = 1'b0;
                            end
                        end
                    end
                end
            end
            ST_GPRE: begin
                if (line_trigger_rise) begin
                    s_nxt.st = ST_GCNT;
                end
            end
            ST_GCNT: begin
                if (line_trigger_rise) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.busy = 1'b0;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase

        // Three-channel measurement counts over both lines; single-channel only after the LED line.
        if (pix_ok && (s_r.st == ST_GCNT || (s_r.st == ST_GPRE && s_r.sensor == SNS_3CH))
                && pix_i.video[9:2] > s_r.thresh && s_r.gcnt != GCNT_MAX) begin
            s_nxt.gcnt = s_r.gcnt + 8'h01;
        end

        s_nxt.led = '0;
        if (s_r.st == ST_GPRE && s_r.sensor != SNS_3CH) begin
            s_nxt.led = mono ? LED_CH0 : s_r.chen;
        end
        s_nxt.corr = corr_sum;

        // Forcing is registered from the next busy state so the pins stay glitch free.
        gain_act = s_nxt.busy & (s_nxt.mode == CMD_GAIN);
        s_nxt.gforce = gain_act;
        s_nxt.ph_out = gain_act ? PHOLD_FULL : s_nxt.ph;
        s_nxt.bv_out = gain_act ? REF_FULL : s_nxt.bv;
        s_nxt.wv_out = gain_act ? REF_FULL : s_nxt.wv;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign sram_o = s_r.sram;
    assign corr_o = s_r.corr;
    assign proc_chan_o = s_r.chan;
    assign led_o = s_r.led;
    assign peak_hold_o = s_r.ph_out;
    assign black_ref_volt_o = s_r.bv_out;
    assign white_ref_volt_o = s_r.wv_out;
    assign black_corr_force_o = s_r.gforce;
    assign white_shd_dis_o = s_r.gforce;
    assign busy_o = s_r.busy;
endmodule : scs_seq
`default_nettype wire

/* bench/scs_seq_chk.sv */
// Port-level assertions for the shading calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module scs_seq_chk
    import scs_pkg::*;
(
    // Clock, reset and APB
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [scs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    // Datapath and control
    input wire logic [7:0] corr_data_i,
    input wire logic [7:0] corr_o,
    input wire scs_pkg::scs_sram_t sram_o,
    input wire logic [1:0] proc_chan_o,
    input wire logic [2:0] led_o,
    input wire logic [7:0] peak_hold_o,
    input wire logic [7:0] black_ref_volt_o,
    input wire logic [7:0] white_ref_volt_o,
    input wire logic black_corr_force_o,
    input wire logic white_shd_dis_o,
    input wire logic busy_o
);
    logic [7:0] adj_r;
    logic [7:0] cfg_r;
    logic wr_c;
    logic signed [9:0] sum_c;
    logic [7:0] exp_c;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // Shadow copies of the writable fields that the properties depend on.
    assign wr_c = psel_i && penable_i && pready_o && pwrite_i;
    assign sum_c = $signed({2'b00, corr_data_i}) + $signed({{2{adj_r[7]}}, adj_r});
    assign exp_c = sum_c < 0 ? 8'h00 : (sum_c > 10'sh0FF ? 8'hFF : sum_c[7:0]);
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            adj_r <= 8'h00;
            cfg_r <= 8'h00;
        end else begin
            if (wr_c && paddr_i == A_ADJ) adj_r <= pwdata_i[7:0];
            if (wr_c && paddr_i == A_CFG) cfg_r <= pwdata_i[7:0];
        end
    end
    apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing");
    status_busy_a: assert property (psel_i && penable_i && pready_o && !pwrite_i
        && paddr_i == A_STATUS |-> prdata_o[STAT_BUSY] == $past(busy_o))
        else $error("status busy bit wrong");
    cmd_busy_a: assert property (wr_c && paddr_i == A_CMD && pwdata_i[1:0] != CMD_NONE
        && !busy_o |=> busy_o) else $error("command did not set busy");
    gain_refs_a: assert property (black_corr_force_o |-> peak_hold_o == PHOLD_FULL
        && black_ref_volt_o == REF_FULL && white_ref_volt_o == REF_FULL)
        else $error("gain references not forced");
    gain_white_a: assert property (black_corr_force_o |-> white_shd_dis_o && busy_o)
        else $error("white shading not disabled");
    adj_corr_a: assert property ($past(nrst_i) |-> corr_o == $past(exp_c))
        else $error("black adjustment wrong");
    one_bank_a: assert property (sram_o.we && !cfg_r[CFG_3SET]
        |-> sram_o.bank == BANK_COMMON) else $error("one-set bank wrong");
    avg_rmw_a: assert property (sram_o.re
        |-> ##2 sram_o.we && sram_o.addr == $past(sram_o.addr, 2))
        else $error("averaging write missing");
    mono_chan_a: assert property (busy_o && cfg_r[1] |-> proc_chan_o == 2'h0)
        else $error("monochrome channel not zero");
    led_gain_a: assert property (led_o != 3'h0 |-> black_corr_force_o)
        else $error("led outside gain mode");
    gain_run_c: cover property (black_corr_force_o && busy_o);
    avg_read_c: cover property (sram_o.re);
    led_on_c: cover property (led_o != 3'h0);
endmodule : scs_seq_chk
`default_nettype wire

/* bench/scs_sensor_model.sv */
// Behavioural line sensor and external shading memory facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module scs_sensor_model
    import scs_pkg::*;
#(
    parameter int LINE = 128,
    parameter int NPIX = 32
) (
    // Clock
    input wire logic clock_i,
    // Memory side
    input wire scs_pkg::scs_sram_t sram_i,
    output logic [8:0] sram_rdata_o,
    // Sensor side
    output logic line_trigger_o,
    output scs_pkg::scs_pix_t pix_o
);
    logic [8:0] mem [0:65535];
    int cyc = 0;
    int k;
    initial begin
        line_trigger_o = 1'b0;
        pix_o = '0;
        sram_rdata_o = 9'h000;
    end
    // The trigger runs free; pixels start well after the sequencer has seen its edge.
    always @(posedge clock_i) begin
        cyc <= (cyc + 1) % LINE;
        k = cyc - 16;
        line_trigger_o <= cyc < 8;
        pix_o.valid <= k >= 0 && k < 3 * NPIX;
        pix_o.chan <= 2'(k % 3);
        pix_o.index <= 13'(k / 3);
        pix_o.video <= 10'(k / 3 * 32);
        pix_o.black <= 8'(k / 3 * 4 + k % 3);
        if (sram_i.we) mem[{sram_i.bank, sram_i.addr}] <= sram_i.wdata;
        // A released data bus shows the inverse of its last value, so it flips every cycle.
        sram_rdata_o <= sram_i.re ? mem[{sram_i.bank, sram_i.addr}] : ~sram_rdata_o;
    end
endmodule : scs_sensor_model
`default_nettype wire

/* bench/scs_seq_tb.sv */
// Self-checking testbench for the shading calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module scs_seq_tb;
    import scs_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i, psel_i, penable_i, pwrite_i, line_trigger_i, pready_o, pslverr_o;
    logic black_corr_force_o, white_shd_dis_o, busy_o, err_seen;
    logic [7:0] paddr_i, corr_data_i, corr_o, peak_hold_o, black_ref_volt_o, white_ref_volt_o;
    logic [31:0] pwdata_i, prdata_o, q_v;
    logic [8:0] sram_rdata_i;
    logic [1:0] proc_chan_o;
    logic [2:0] led_o, led_seen;
    scs_pix_t pix_i;
    scs_sram_t sram_o;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] adj_t [3] = '{8'h80, 8'h7F, 8'hF0};
    logic [7:0] cin_t [3] = '{8'h10, 8'hC0, 8'h20};
    logic [7:0] cexp_t [3] = '{8'h00, 8'hFF, 8'h10};
    scs_seq i_dut (.*);
    scs_sensor_model i_model (
        .clock_i(clock_i),
        .sram_i(sram_o),
        .sram_rdata_o(sram_rdata_i),
        .line_trigger_o(line_trigger_i),
        .pix_o(pix_i)
    );
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (nrst_i) led_seen <= led_seen | led_o;
    end
    function automatic logic [31:0] blk(input int i, input int c);
        return 32'(i * 4 + c);
    endfunction : blk
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // The answer is looked at mid-cycle, where it has settled; the edge after ends it.
        do begin
            @(negedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        err_seen = pslverr_o;
        if (n >= 20) bad_count++;
        @(posedge clock_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q_v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, q_v);
        chk("reg", e, q_v);
    endtask : rd
    // Commands go out just after a trigger falls, so no line start races the accept.
    task automatic run(input logic [7:0] cfg, input logic [1:0] cmd, input int lines);
        int n;
        int t;
        logic tp;
        n = 0;
        t = 0;
        wr(A_CFG, {24'h0, cfg});
        @(negedge line_trigger_i);
        wr(A_CMD, {30'h0, cmd});
        rd(A_STATUS, 32'h80);
        tp = line_trigger_i;
        while (busy_o !== 1'b0 && t < 20000) begin
            @(posedge clock_i);
            t++;
            n += int'(line_trigger_i && !tp);
            tp = line_trigger_i;
        end
        if (t >= 20000) bad_count++;
        chk("line_trigger", 32'(lines), 32'(n));
        rd(A_STATUS, 32'h0);
    endtask : run
    initial begin
        repeat (60000) @(posedge clock_i);
        bad_count++;
        close_out();
    end
    initial begin
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        corr_data_i = 8'h00;
        led_seen = 3'h0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(A_STATUS, 32'h0);
        rd(A_REFS, 32'h0);
        apb(1'b0, 8'h30, 32'h0, q_v);
        chk("slverr", 32'h1, 32'(err_seen));
        wr(A_REFS, 32'h00123456);
        wr(A_BREF, 32'h1);
        wr(A_THRESH, 32'h80);
        for (int i = 0; i < 3; i++) begin
            wr(A_ADJ, {24'h0, adj_t[i]});
            corr_data_i <= cin_t[i];
            repeat (2) @(posedge clock_i);
            chk("corr", {24'h0, cexp_t[i]}, {24'h0, corr_o});
        end
        wr(A_ADJ, 32'h0);
        run(8'h20, CMD_OFS, 4);
        rd(8'h58, blk(8, 1));
        rd(8'h5C, blk(9, 1));
        run(8'h14, CMD_OFS, 8);
        for (int c = 0; c < 3; c++) begin
            rd(8'(A_OFFS + 8 * c), blk(8, c));
            rd(8'(A_OFFS + 8 * c + 4), blk(9, c));
        end
        run(8'h42, CMD_OFS, 4);
        rd(8'h58, blk(8, 0));
        rd(8'h5C, blk(9, 0));
        run(8'h10, CMD_P2P, 18);
        wr(A_AVG, 32'h1);
        run(8'h10, CMD_P2P, 34);
        wr(A_AVG, 32'h0);
        for (int i = 0; i < 32; i++) begin
            chk("sram", blk(i, 0), 32'(i_model.mem[{3'h3, 13'(i)}]));
        end
        run(8'h15, CMD_P2P, 50);
        run(8'h15, CMD_OFS, 8);
        run(8'h11, CMD_OFS, 4);
        run(8'h20, CMD_GAIN, 3);
        rd(A_GCNT, 32'h1E);
        chk("led", 32'h0, 32'(led_seen));
        run(8'h21, CMD_GAIN, 3);
        rd(A_GCNT, 32'h0F);
        chk("led", 32'h2, 32'(led_seen));
        rd(A_REFS, 32'h00123456);
        chk("peak", 32'h56, 32'(peak_hold_o));
        close_out();
    end
endmodule : scs_seq_tb
bind scs_seq scs_seq_chk i_chk (.*);
`default_nettype wire
